// ---- design/aac_pkg.sv ----
/*
 * Constants shared by the axis auxiliary control block: the register map,
 * field positions, reset values and the widths of the axis datapath.
 * Assumes a 32-bit APB master and one 100 MHz clock for the whole block.
 */
package aac_pkg;
    // Register byte offsets
    localparam logic [7:0] AAC_OFF_CTRL = 8'h00;
    localparam logic [7:0] AAC_OFF_LUBE_THR = 8'h04;
    localparam logic [7:0] AAC_OFF_LUBE_THR_MM = 8'h08;
    localparam logic [7:0] AAC_OFF_TRAVEL = 8'h0c;
    localparam logic [7:0] AAC_OFF_WRAP_UP = 8'h10;
    localparam logic [7:0] AAC_OFF_WRAP_LO = 8'h14;
    localparam logic [7:0] AAC_OFF_COMP_TURNS = 8'h18;
    localparam logic [7:0] AAC_OFF_COMP_INC = 8'h1c;
    localparam logic [7:0] AAC_OFF_STOP_THR = 8'h20;
    localparam logic [7:0] AAC_OFF_VEL_OFFSET = 8'h24;
    localparam logic [7:0] AAC_OFF_VEL_FLOOR = 8'h28;
    localparam logic [7:0] AAC_OFF_POSITION = 8'h2c;
    localparam logic [7:0] AAC_OFF_STATUS = 8'h30;
    localparam logic [7:0] AAC_OFF_IRQ_STAT = 8'h34;
    localparam logic [7:0] AAC_OFF_IRQ_MASK = 8'h38;
    localparam logic [7:0] AAC_OFF_VEL_CMD = 8'h3c;

    // Control register fields
    localparam int AAC_CTRL_LUBE_EN = 0;
    localparam int AAC_CTRL_MODULE = 1;
    localparam int AAC_CTRL_COMP_EN = 2;
    localparam int AAC_CTRL_POL_REV = 3;
    localparam int AAC_CTRL_CW_NEG = 4;
    localparam int AAC_CTRL_CCW_NEG = 5;
    localparam int AAC_CTRL_PLC_CTL = 6;
    localparam int AAC_CTRL_W = 7;
    localparam logic [6:0] AAC_CTRL_RST = 7'h20;

    // Interrupt status bits
    localparam int AAC_IRQ_LUBE_REQ = 0;
    localparam int AAC_IRQ_LUBE_DONE = 1;
    localparam int AAC_IRQ_STOPPED = 2;
    localparam int AAC_IRQ_CMD_REJ = 3;
    localparam int AAC_IRQ_W = 4;

    // Field widths, limits and reset values
    localparam int AAC_THR_W = 28;
    localparam logic [27:0] AAC_THR_MAX = 28'h0bebc200;
    localparam logic [31:0] AAC_THR_PER_MM = 32'h00002710;
    localparam logic signed [31:0] AAC_WRAP_UP_RST = 32'sh00000168;
    localparam logic signed [31:0] AAC_WRAP_LO_RST = 32'sh00000000;
    localparam logic [14:0] AAC_TURNS_RST = 15'h0001;
    localparam logic [16:0] AAC_STOP_THR_RST = 17'h00001;
    localparam logic [16:0] AAC_STOP_THR_MAX = 17'h186a0;
    localparam logic signed [15:0] AAC_DAC_MAX = 16'sh7fff;
    localparam logic signed [15:0] AAC_DAC_MIN = -16'sh7fff;
endpackage : aac_pkg

// ---- design/aac_axis_aux.sv ----
/*
 * Per-axis auxiliary control: travel-based lubrication handshake, rotary
 * position wrap with module compensation, spindle zero-speed detection,
 * spindle direction sign and the analog velocity command with offset and
 * floor. Registers sit on an APB slave with a masked level interrupt.
 * Assumes the motion core feeds position steps, speed and command on the
 * same clock; the lubrication acknowledge comes from another domain.
 */
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Threshold register, zero disables lubrication requests
// - Enable bit gates lubrication requests per axis
// - Travel reaching threshold raises lubrication request
// - Acknowledge drops request and clears travel
// - Threshold in 0.0001 mm, millimetre copy exported
// - Module mode wraps position between limits
// - Limits ignored unless module mode selected
// - Module error correction added whole once per turn count
// - Speed below threshold means spindle stopped
// - C-axis and controller command need zero speed
// - Configurable sign for clockwise and counter-clockwise
// - Runtime reverse inverts signs, settings untouched
// - Signed offset added, saturated to full scale
// - Linear converter units, 32767 is full scale
// - Minimum command floor, default zero
module aac_axis_aux (
    input wire logic sys_clk_i, // 100 MHz clock
    input wire logic sys_rst_i, // Synchronous reset, active high
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB access phase
    input wire logic pwrite_i, // APB direction
    input wire logic [7:0] paddr_i, // APB byte address
    input wire logic [31:0] pwdata_i, // APB write data
    output logic [31:0] prdata_o, // APB read data
    output logic pready_o, // APB ready
    output logic pslverr_o, // APB error, unmapped address
    input wire logic step_valid_i, // Position step present
    input wire logic signed [15:0] step_i, // Signed position step
    input wire logic [16:0] speed_rpm_i, // Spindle speed magnitude
    input wire logic spin_ccw_i, // Direction: 1 counter-clockwise
    input wire logic [14:0] core_vel_mag_i, // Core velocity magnitude
    input wire logic plc_cmd_valid_i, // Controller velocity command strobe
    input wire logic [14:0] plc_spindle_velocity_cmd_i, // Controller magnitude
    input wire logic c_axis_req_i, // Request to enter C-axis mode
    input wire logic lube_done_ack_i, // Lubrication done, asynchronous
    output logic lube_request_o, // Lubrication request to controller
    output logic [31:0] lube_threshold_mm_o, // Threshold in millimetres
    output logic signed [31:0] position_o, // Wrapped axis position
    output logic spindle_stopped_o, // Zero-speed condition
    output logic c_axis_mode_o, // Spindle running as C axis
    output logic signed [15:0] dac_cmd_o, // Converter command units
    output logic irq_o // Level interrupt
);
    import aac_pkg::*;

    logic [AAC_CTRL_W-1:0] ctrl_reg;
    logic [AAC_THR_W-1:0] lube_thr_reg;
    logic signed [31:0] wrap_up_reg;
    logic signed [31:0] wrap_lo_reg;
    logic [14:0] turns_reg;
    logic signed [15:0] comp_inc_reg;
    logic [16:0] stop_thr_reg;
    logic signed [15:0] offset_reg;
    logic [14:0] floor_reg;
    logic [AAC_IRQ_W-1:0] irq_stat_reg;
    logic [AAC_IRQ_W-1:0] irq_mask_reg;
    logic [31:0] travel_reg;
    logic lube_req_reg;
    logic ack_s1_reg, ack_s2_reg, ack_s3_reg, ack_reg;
    logic signed [31:0] pos_reg;
    logic [14:0] turn_cnt_reg;
    logic stopped_reg, c_axis_reg;
    logic [14:0] plc_mag_reg;
    logic signed [15:0] dac_reg;
    logic [31:0] thr_mm_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg, irq_reg;

    logic apb_acc, wr_en, rd_hit;
    logic [31:0] rd_val;
    logic [AAC_IRQ_W-1:0] irq_set;
    logic [15:0] step_abs;
    logic lube_fire, lube_clear;
    logic signed [31:0] pos_sum, span, pos_next;
    logic wrap_up, wrap_dn;
    logic stopped_now, cmd_rej;
    logic [14:0] mag;
    logic neg_sign;
    logic signed [17:0] vel_s, sum_s;
    logic signed [15:0] dac_next;

    // Access phase answered on the second cycle so ready comes from a flop
    assign apb_acc = psel_i && penable_i && !pready_reg;
    assign wr_en = apb_acc && pwrite_i;

    // Read multiplexer and address decode
    always_comb begin
        rd_val = 32'h00000000;
        rd_hit = 1'b1;
        case (paddr_i)
            AAC_OFF_CTRL: rd_val = {25'h0000000, ctrl_reg};
            AAC_OFF_LUBE_THR: rd_val = {4'h0, lube_thr_reg};
            AAC_OFF_LUBE_THR_MM: rd_val = thr_mm_reg;
            AAC_OFF_TRAVEL: rd_val = travel_reg;
            AAC_OFF_WRAP_UP: rd_val = wrap_up_reg;
            AAC_OFF_WRAP_LO: rd_val = wrap_lo_reg;
            AAC_OFF_COMP_TURNS: rd_val = {17'h00000, turns_reg};
            AAC_OFF_COMP_INC: rd_val = {{16{comp_inc_reg[15]}}, comp_inc_reg};
            AAC_OFF_STOP_THR: rd_val = {15'h0000, stop_thr_reg};
            AAC_OFF_VEL_OFFSET: rd_val = {{16{offset_reg[15]}}, offset_reg};
            AAC_OFF_VEL_FLOOR: rd_val = {17'h00000, floor_reg};
            AAC_OFF_POSITION: rd_val = pos_reg;
            AAC_OFF_STATUS: rd_val = {29'h00000000, c_axis_reg, stopped_reg, lube_req_reg};
            AAC_OFF_IRQ_STAT: rd_val = {28'h0000000, irq_stat_reg};
            AAC_OFF_IRQ_MASK: rd_val = {28'h0000000, irq_mask_reg};
            AAC_OFF_VEL_CMD: rd_val = {{16{dac_reg[15]}}, dac_reg};
            default: rd_hit = 1'b0;
        endcase
    end

    // APB answer flops
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= apb_acc;
            pslverr_reg <= apb_acc && !rd_hit;
            if (apb_acc && !pwrite_i) begin
                prdata_reg <= rd_val;
            end
        end
    end

    // Configuration registers; out-of-range values are clamped at write
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= AAC_CTRL_RST;
            lube_thr_reg <= '0;
            wrap_up_reg <= AAC_WRAP_UP_RST;
            wrap_lo_reg <= AAC_WRAP_LO_RST;
            turns_reg <= AAC_TURNS_RST;
            comp_inc_reg <= 16'sh0000;
            stop_thr_reg <= AAC_STOP_THR_RST;
            offset_reg <= 16'sh0000;
            floor_reg <= 15'h0000;
            irq_mask_reg <= '0;
        end else if (wr_en) begin
            case (paddr_i)
                AAC_OFF_CTRL: ctrl_reg <= pwdata_i[AAC_CTRL_W-1:0];
                AAC_OFF_LUBE_THR: begin
                    if (pwdata_i[31:AAC_THR_W] != 4'h0 || pwdata_i[27:0] > AAC_THR_MAX) begin
                        lube_thr_reg <= AAC_THR_MAX;
                    end else begin
                        lube_thr_reg <= pwdata_i[27:0];
                    end
                end
                AAC_OFF_WRAP_UP: wrap_up_reg <= pwdata_i;
                AAC_OFF_WRAP_LO: wrap_lo_reg <= pwdata_i;
                // A zero turn count would stall compensation, so keep at least one
                AAC_OFF_COMP_TURNS: turns_reg <= (pwdata_i[14:0] == 15'h0000) ?
                    AAC_TURNS_RST : pwdata_i[14:0];
                AAC_OFF_COMP_INC: comp_inc_reg <= (pwdata_i[15:0] == 16'h8000) ?
                    AAC_DAC_MIN : pwdata_i[15:0];
                AAC_OFF_STOP_THR: stop_thr_reg <= (pwdata_i[16:0] > AAC_STOP_THR_MAX) ?
                    AAC_STOP_THR_MAX : pwdata_i[16:0];
                AAC_OFF_VEL_OFFSET: offset_reg <= (pwdata_i[15:0] == 16'h8000) ?
                    AAC_DAC_MIN : pwdata_i[15:0];
                AAC_OFF_VEL_FLOOR: floor_reg <= pwdata_i[14:0];
                AAC_OFF_IRQ_MASK: irq_mask_reg <= pwdata_i[AAC_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Millimetre copy for the controller; constant divide, one cycle late
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            thr_mm_reg <= 32'h00000000;
        end else begin
            thr_mm_reg <= {4'h0, lube_thr_reg} / AAC_THR_PER_MM;
        end
    end

    // Acknowledge crosses in: three flops, a change counts once two agree
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
            ack_s3_reg <= 1'b0;
            ack_reg <= 1'b0;
        end else begin
            ack_s1_reg <= lube_done_ack_i;
            ack_s2_reg <= ack_s1_reg;
            ack_s3_reg <= ack_s2_reg;
            if (ack_s2_reg == ack_s3_reg) begin
                ack_reg <= ack_s3_reg;
            end
        end
    end

    // Lubrication handshake
    assign step_abs = step_i[15] ? 16'(-step_i) : 16'(step_i);
    assign lube_fire = ctrl_reg[AAC_CTRL_LUBE_EN] && lube_thr_reg != '0 && !lube_req_reg &&
        travel_reg >= {4'h0, lube_thr_reg};
    assign lube_clear = lube_req_reg && ack_reg;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            lube_req_reg <= 1'b0;
            travel_reg <= 32'h00000000;
        end else if (lube_clear) begin
            lube_req_reg <= 1'b0;
            travel_reg <= 32'h00000000;
        end else if (lube_fire) begin
            lube_req_reg <= 1'b1;
        end else if (step_valid_i && !lube_req_reg && travel_reg != 32'hffffffff) begin
            // Accumulation pauses while the request waits for the controller
            travel_reg <= travel_reg + {16'h0000, step_abs};
        end
    end

    // Position update with wrap; compensation lands on the last turn of a group
    assign span = wrap_up_reg - wrap_lo_reg;
    assign pos_sum = pos_reg + 32'(step_i);
    assign wrap_up = ctrl_reg[AAC_CTRL_MODULE] && pos_sum >= wrap_up_reg;
    assign wrap_dn = ctrl_reg[AAC_CTRL_MODULE] && pos_sum < wrap_lo_reg;

    always_comb begin
        pos_next = pos_sum;
        if (wrap_up) begin
            pos_next = pos_sum - span;
            if (ctrl_reg[AAC_CTRL_COMP_EN] && turn_cnt_reg + 15'h0001 >= turns_reg) begin
                pos_next = pos_sum - span + 32'(comp_inc_reg);
            end
        end else if (wrap_dn) begin
            pos_next = pos_sum + span;
            if (ctrl_reg[AAC_CTRL_COMP_EN] && turn_cnt_reg == 15'h0000) begin
                pos_next = pos_sum + span - 32'(comp_inc_reg);
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pos_reg <= 32'sh00000000;
            turn_cnt_reg <= 15'h0000;
        end else if (step_valid_i) begin
            pos_reg <= pos_next;
            if (!ctrl_reg[AAC_CTRL_MODULE] || !ctrl_reg[AAC_CTRL_COMP_EN]) begin
                turn_cnt_reg <= 15'h0000;
            end else if (wrap_up) begin
                turn_cnt_reg <= (turn_cnt_reg + 15'h0001 >= turns_reg) ? 15'h0000 :
                    turn_cnt_reg + 15'h0001;
            end else if (wrap_dn) begin
                turn_cnt_reg <= (turn_cnt_reg == 15'h0000) ? turns_reg - 15'h0001 :
                    turn_cnt_reg - 15'h0001;
            end
        end
    end

    // Zero-speed gate for C-axis entry and controller commands
    assign stopped_now = speed_rpm_i < stop_thr_reg;
    assign cmd_rej = plc_cmd_valid_i && !stopped_now;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            stopped_reg <= 1'b1; // Idle spindle is at rest: no false stop event
            c_axis_reg <= 1'b0;
            plc_mag_reg <= 15'h0000;
        end else begin
            stopped_reg <= stopped_now;
            // Leaving C-axis mode needs no zero speed, entering does
            if (!c_axis_req_i) begin
                c_axis_reg <= 1'b0;
            end else if (stopped_now) begin
                c_axis_reg <= 1'b1;
            end
            if (plc_cmd_valid_i && stopped_now) begin
                plc_mag_reg <= plc_spindle_velocity_cmd_i;
            end
        end
    end

    // Velocity command: floor, sign, offset, saturate to converter full scale
    assign mag = ctrl_reg[AAC_CTRL_PLC_CTL] ? plc_mag_reg : core_vel_mag_i;
    assign neg_sign = (spin_ccw_i ? ctrl_reg[AAC_CTRL_CCW_NEG] : ctrl_reg[AAC_CTRL_CW_NEG]) ^
        ctrl_reg[AAC_CTRL_POL_REV];

    always_comb begin
        vel_s = 18'(signed'({3'b000, mag}));
        if (mag != 15'h0000 && mag < floor_reg) begin
            vel_s = 18'(signed'({3'b000, floor_reg}));
        end
        if (neg_sign) begin
            vel_s = -vel_s;
        end
        sum_s = vel_s + 18'(offset_reg);
        if (sum_s > 18'(AAC_DAC_MAX)) begin
            dac_next = AAC_DAC_MAX;
        end else if (sum_s < 18'(AAC_DAC_MIN)) begin
            dac_next = AAC_DAC_MIN;
        end else begin
            dac_next = sum_s[15:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            dac_reg <= 16'sh0000;
        end else begin
            dac_reg <= dac_next;
        end
    end

    // Sticky events; a set in the clearing cycle wins over the write of one
    assign irq_set[AAC_IRQ_LUBE_REQ] = lube_fire;
    assign irq_set[AAC_IRQ_LUBE_DONE] = lube_clear;
    assign irq_set[AAC_IRQ_STOPPED] = stopped_now && !stopped_reg;
    assign irq_set[AAC_IRQ_CMD_REJ] = cmd_rej;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            irq_stat_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            if (wr_en && paddr_i == AAC_OFF_IRQ_STAT) begin
                irq_stat_reg <= (irq_stat_reg & ~pwdata_i[AAC_IRQ_W-1:0]) | irq_set;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_set;
            end
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign lube_request_o = lube_req_reg;
    assign lube_threshold_mm_o = thr_mm_reg;
    assign position_o = pos_reg;
    assign spindle_stopped_o = stopped_reg;
    assign c_axis_mode_o = c_axis_reg;
    assign dac_cmd_o = dac_reg;
    assign irq_o = irq_reg;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_lube_zero_thr: assert property (lube_thr_reg == '0 |=> !$rose(lube_req_reg))
        else $error("Lube request raised with zero threshold");
    a_lube_enable: assert property (!ctrl_reg[AAC_CTRL_LUBE_EN] |=> !$rose(lube_req_reg))
        else $error("Lube request raised while disabled");
    a_lube_raise: assert property (lube_fire && !lube_clear |=> lube_request_o)
        else $error("Lube request not raised at threshold");
    a_lube_ack_clear: assert property (lube_req_reg && ack_reg |=>
        !lube_request_o && travel_reg == 32'h00000000)
        else $error("Acknowledge did not clear request and travel");
    a_lube_hold: assert property (lube_req_reg && !ack_reg |=>
        lube_req_reg && $stable(travel_reg))
        else $error("Request dropped or travel moved before acknowledge");
    a_ack_sync: assert property ($rose(lube_done_ack_i) ##1 lube_done_ack_i [*3] |=>
        ack_reg)
        else $error("Held acknowledge not seen within four cycles");
    a_thr_mm: assert property ($stable(lube_thr_reg) |=>
        thr_mm_reg == {4'h0, $past(lube_thr_reg)} / AAC_THR_PER_MM)
        else $error("Millimetre threshold wrong");
    a_wrap_range: assert property (ctrl_reg[AAC_CTRL_MODULE] && !ctrl_reg[AAC_CTRL_COMP_EN] &&
        step_valid_i && $stable(wrap_up_reg) && wrap_up_reg > wrap_lo_reg &&
        pos_reg >= wrap_lo_reg && pos_reg < wrap_up_reg && step_abs < 16'(span) |=>
        pos_reg >= wrap_lo_reg && pos_reg < wrap_up_reg)
        else $error("Module position left its range");
    a_no_module: assert property (!ctrl_reg[AAC_CTRL_MODULE] && step_valid_i |=>
        pos_reg == $past(pos_reg) + 32'($past(step_i)))
        else $error("Position wrapped outside module mode");
    a_stop_flag: assert property (speed_rpm_i < stop_thr_reg |=> spindle_stopped_o)
        else $error("Stopped flag missing below threshold");
    a_c_axis_gate: assert property ($rose(c_axis_reg) |-> $past(stopped_now))
        else $error("C-axis entered at speed");
    a_polarity: assert property (ctrl_reg[AAC_CTRL_PLC_CTL] == 1'b0 && offset_reg == 16'sh0000 &&
        core_vel_mag_i >= floor_reg && core_vel_mag_i != 15'h0000 && neg_sign |=>
        dac_cmd_o < 16'sh0000)
        else $error("Negative sign not applied");
    a_dac_range: assert property (dac_cmd_o >= AAC_DAC_MIN)
        else $error("Converter command beyond full scale");

    c_lube_cycle: cover property (lube_req_reg ##[1:50] !lube_req_reg);
    c_wrap_comp: cover property (wrap_up && step_valid_i && ctrl_reg[AAC_CTRL_COMP_EN]);
    c_c_axis: cover property ($rose(c_axis_reg));
    c_cmd_rej: cover property (cmd_rej);
endmodule : aac_axis_aux

`default_nettype wire

// ---- verification/aac_plc_model.sv ----
/*
 * Logic controller partner for the lubrication handshake.
 * Assumes the bench clock and reset; the bench sets the acknowledge delay.
 */
`timescale 1ns/1ps
`default_nettype none

module aac_plc_model (
    input wire logic sys_clk_i, // Clock
    input wire logic sys_rst_i, // Reset, active high
    input wire logic [7:0] delay_i, // Cycles spent lubricating
    input wire logic lube_request_i, // Request from the block
    output logic lube_done_ack_o // Done flag back to the block
);
    logic [7:0] cnt_reg;

    // Lubricate for the delay, then hold done until the request drops
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !lube_request_i) begin
            cnt_reg <= 8'h00;
            lube_done_ack_o <= 1'b0;
        end else if (cnt_reg >= delay_i) begin
            lube_done_ack_o <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule : aac_plc_model

`default_nettype wire

// ---- verification/testbench.sv ----
/*
 * Self-checking bench for the axis auxiliary block: APB reads queue their
 * expected words, a monitor compares them when pready comes.
 * Assumes the partner model answers the lubrication request.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import aac_pkg::*;
    logic sys_clk_i, sys_rst_i, psel, pen, pwr, sv, ccw, pv, creq, ack, rdy, req, stp, cax, irq;
    logic perr;
    logic [7:0] pa;
    logic [31:0] pwd, prd, thr_mm;
    logic signed [15:0] step, dac;
    logic signed [31:0] pos;
    logic [16:0] spd;
    logic [14:0] mag, pmag;
    int errors, check_count, tot, s;
    logic [39:0] q[$];
    // ctrl, ccw, magnitude, floor, offset, expected command
    int tc[9][6] = '{'{32'h20, 0, 3277, 0, 0, 3277}, '{32'h20, 1, 3277, 0, 0, -3277},
        '{32'h30, 0, 3277, 0, 0, -3277}, '{32'h28, 1, 3277, 0, 0, 3277},
        '{32'h28, 0, 3277, 0, 0, -3277}, '{32'h20, 0, 32000, 0, 1000, 32767},
        '{32'h20, 1, 32000, 0, -1000, -32767}, '{32'h20, 0, 10, 500, 0, 500},
        '{32'h20, 0, 0, 500, 5, 5}};

    aac_axis_aux aac_axis_aux_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(rdy), .pslverr_o(perr), .step_valid_i(sv), .step_i(step), .speed_rpm_i(spd),
        .spin_ccw_i(ccw), .core_vel_mag_i(mag), .plc_cmd_valid_i(pv),
        .plc_spindle_velocity_cmd_i(pmag), .c_axis_req_i(creq), .lube_done_ack_i(ack),
        .lube_request_o(req), .lube_threshold_mm_o(thr_mm), .position_o(pos),
        .spindle_stopped_o(stp), .c_axis_mode_o(cax), .dac_cmd_o(dac), .irq_o(irq));
    aac_plc_model aac_plc_model_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .delay_i(8'h28), .lube_request_i(req), .lube_done_ack_o(ack));

    // Free-running 100 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task give_verdict;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        check_count++;
        if (v !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, v);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask : cyc

    // Bounded wait on the lubrication request; a missed level ends the run
    task automatic hold_for(input logic v, input string nm);
        int n;
        n = 0;
        while (req !== v && n < 200) begin
            cyc(1);
            n++;
        end
        chk(nm, 32'(v), 32'(req));
        if (req !== v) give_verdict();
    endtask : hold_for

    // One APB transfer; the request stands until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        cyc(1);
        pen <= 1'b1;
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        pen <= 1'b0;
        psel <= 1'b0;
        if (rdy !== 1'b1) begin
            chk("pready", 32'h1, 32'(rdy));
            give_verdict();
        end
        cyc(1);
    endtask : apb

    task rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back({a, e});
        apb(1'b0, a, 32'h0);
    endtask : rd

    // A step stays one cycle, then two idle cycles let the outputs settle
    task mv(input int d);
        sv <= 1'b1;
        step <= 16'(d);
        cyc(1);
        sv <= 1'b0;
        cyc(2);
    endtask : mv

    // Read data is compared against the oldest note in the pready cycle
    always @(posedge sys_clk_i) begin
        logic [39:0] t;
        if (rdy === 1'b1 && psel === 1'b1 && pwr === 1'b0) begin
            t = (q.size() > 0) ? q.pop_front() : 40'hff_0bad0bad;
            chk($sformatf("reg %h", t[39:32]), t[31:0], prd);
            chk("pslverr", 32'(t[39:32] > AAC_OFF_VEL_CMD), 32'(perr));
        end
    end

    // Main sequence
    initial begin
        {sys_rst_i, psel, pen, pwr, pa, pwd, sv, step, spd, ccw, mag, pv, pmag, creq} = '0;
        sys_rst_i = 1'b1;
        errors = 0;
        check_count = 0;
        void'($urandom(33));
        cyc(2);
        sys_rst_i <= 1'b0;
        rd(AAC_OFF_CTRL, 32'h20);
        rd(AAC_OFF_LUBE_THR, 32'h0);
        rd(AAC_OFF_WRAP_UP, 32'h168);
        rd(AAC_OFF_COMP_TURNS, 32'h1);
        rd(AAC_OFF_STOP_THR, 32'h1);
        rd(AAC_OFF_VEL_FLOOR, 32'h0);
        rd(8'hfc, 32'h0);
        // Lubrication round with random paired steps, position back to zero
        apb(1'b1, AAC_OFF_IRQ_MASK, 32'h1);
        apb(1'b1, AAC_OFF_LUBE_THR, 32'd20000);
        apb(1'b1, AAC_OFF_CTRL, 32'h21);
        rd(AAC_OFF_LUBE_THR_MM, 32'h2);
        chk("threshold mm", 32'h2, thr_mm);
        tot = 0;
        while (tot < 20000) begin
            s = $urandom_range(3000, 1);
            chk("lube request", 32'h0, 32'(req));
            mv(s);
            tot += s;
            if (tot < 20000) tot += s;
            mv(-s);
        end
        hold_for(1'b1, "lube request");
        mv(500);
        mv(-500);
        rd(AAC_OFF_TRAVEL, tot);
        chk("irq", 32'h1, 32'(irq));
        apb(1'b1, AAC_OFF_IRQ_STAT, 32'h1);
        chk("irq", 32'h0, 32'(irq));
        hold_for(1'b0, "lube request");
        rd(AAC_OFF_TRAVEL, 32'h0);
        apb(1'b1, AAC_OFF_CTRL, 32'h20);
        repeat (5) begin
            mv(3000);
            mv(-3000);
        end
        chk("lube request", 32'h0, 32'(req));
        // Wrap in both directions, no lubrication request at zero threshold
        apb(1'b1, AAC_OFF_LUBE_THR, 32'h0);
        apb(1'b1, AAC_OFF_CTRL, 32'h23);
        repeat (4) mv(100);
        chk("position", 32'd40, pos);
        mv(-100);
        chk("position", 32'd300, pos);
        chk("lube request", 32'h0, 32'(req));
        // Compensation on: whole correction on each completed turn group of one
        apb(1'b1, AAC_OFF_COMP_INC, 32'd7);
        apb(1'b1, AAC_OFF_CTRL, 32'h26);
        mv(100);
        chk("position", 32'd47, pos);
        mv(-100);
        chk("position", 32'd300, pos);
        apb(1'b1, AAC_OFF_CTRL, 32'h20);
        mv(100);
        chk("position", 32'd400, pos);
        // Zero-speed boundary gates C axis and the controller command
        apb(1'b1, AAC_OFF_STOP_THR, 32'd50);
        spd <= 17'd50;
        creq <= 1'b1;
        cyc(3);
        chk("stopped", 32'h0, 32'(stp));
        chk("c axis", 32'h0, 32'(cax));
        spd <= 17'd49;
        cyc(3);
        chk("stopped", 32'h1, 32'(stp));
        chk("c axis", 32'h1, 32'(cax));
        apb(1'b1, AAC_OFF_CTRL, 32'h60);
        spd <= 17'd1000;
        pmag <= 15'd700;
        repeat (2) begin
            cyc(3);
            pv <= 1'b1;
            cyc(1);
            pv <= 1'b0;
            cyc(3);
            chk("dac", (spd === 17'd0) ? 32'd700 : 32'h0, dac);
            spd <= 17'd0;
        end
        // Signs, reverse, offset saturation and floor
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, AAC_OFF_CTRL, tc[i][0]);
            apb(1'b1, AAC_OFF_VEL_FLOOR, tc[i][3]);
            apb(1'b1, AAC_OFF_VEL_OFFSET, tc[i][4]);
            ccw <= tc[i][1][0];
            mag <= 15'(tc[i][2]);
            cyc(3);
            chk("dac", tc[i][5], dac);
        end
        give_verdict();
    end
endmodule : testbench

`default_nettype wire
